/* File: verilog/iopr_defs.svh */
`ifndef IOPR_DEFS_SVH
`define IOPR_DEFS_SVH

// Register byte offsets
`define IOPR_OFF_DIR 12'h000
`define IOPR_OFF_LATCH 12'h004
`define IOPR_OFF_LEVEL 12'h008
`define IOPR_OFF_ANALOG 12'h00c
`define IOPR_OFF_PERIPH_EN 12'h010
`define IOPR_OFF_MAP_BASE 12'h020

// Reset values
`define IOPR_DIR_RESET 32'hffffffff
`define IOPR_LATCH_RESET 32'h00000000
`define IOPR_ANALOG_RESET 32'h00000000
`define IOPR_MAP_RESET 6'h00

// Output map field layout: two 6-bit selectors per word
`define IOPR_SEL_W 6
`define IOPR_SEL_LO_POS 0
`define IOPR_SEL_HI_POS 8
`define IOPR_SEL_MAX 6'h1b

`endif

/* File: verilog/iopr_pkg.sv */
package iopr_pkg;

	typedef logic [5:0] iopr_sel_t;

	typedef enum logic [1:0] {
		IOPR_IDLE = 2'b00,
		IOPR_ACCESS = 2'b01
	} iopr_apb_state_t;

endpackage

/* File: verilog/iopr_sync.sv */
`timescale 1ns/1ps
module iopr_sync #(
	parameter int WIDTH = 32
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Data
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1 <= '0;
			sync_out <= '0;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule

/* File: verilog/iopr_outmap.sv */
`timescale 1ns/1ps
`include "iopr_defs.svh"
module iopr_outmap #(
	parameter int NUM_SRC = 28
) (
	// Selection
	input wire iopr_pkg::iopr_sel_t sel,
	input wire logic [NUM_SRC-1:0] src_data,
	input wire logic [NUM_SRC-1:0] src_drive,
	// Result
	output logic map_data,
	output logic map_drive
);
	// Null and unassigned codes leave the pin to the fixed peripheral or the port
	wire sel_valid = (sel != 6'h00) && (sel <= `IOPR_SEL_MAX) && (32'(sel) < NUM_SRC);
	assign map_data = sel_valid ? src_data[sel[4:0]] : 1'b0;
	assign map_drive = sel_valid ? src_drive[sel[4:0]] : 1'b0;

	initial begin
		if (NUM_SRC > 32 || NUM_SRC < 1)
			$error("NUM_SRC out of range");
	end
endmodule

/* File: verilog/iopr_port.sv */
`timescale 1ns/1ps
`include "iopr_defs.svh"
module iopr_port #(
	parameter int NUM_PINS = 16,
	parameter logic [31:0] IMPL_MASK = 32'h0000ffff,
	parameter logic [31:0] REMAP_MASK = 32'h0000ffff,
	parameter int NUM_SRC = 28
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Fixed peripherals sharing pins
	input wire logic [NUM_PINS-1:0] fixed_data,
	input wire logic [NUM_PINS-1:0] fixed_drive,
	// Remappable peripheral outputs, index is selector code
	input wire logic [NUM_SRC-1:0] src_data,
	input wire logic [NUM_SRC-1:0] src_drive,
	// Peripheral inputs and analog selection
	output logic [NUM_PINS-1:0] periph_in,
	output logic [NUM_PINS-1:0] analog_sel,
	// Pads
	input wire logic [NUM_PINS-1:0] pad_in,
	output logic [NUM_PINS-1:0] pad_out,
	output logic [NUM_PINS-1:0] pad_oe
);
	localparam int NUM_MAP = (NUM_PINS + 1) / 2;
	localparam logic [31:0] PIN_MASK = IMPL_MASK & ((NUM_PINS >= 32) ? 32'hffffffff :
		((32'h1 << NUM_PINS) - 32'h1));

	initial begin
		if (NUM_PINS < 1 || NUM_PINS > 32)
			$error("NUM_PINS must be 1 to 32");
		// Selector codes are decoded from five bits, so at most 32 sources exist
		if (NUM_SRC < 1 || NUM_SRC > 32)
			$error("NUM_SRC must be 1 to 32");
	end

	logic [NUM_PINS-1:0] dir;
	logic [NUM_PINS-1:0] latch;
	logic [NUM_PINS-1:0] analog;
	logic [NUM_PINS-1:0] periph_en;
	logic [NUM_PINS-1:0] level;
	iopr_pkg::iopr_sel_t map_sel [NUM_PINS];
	iopr_pkg::iopr_apb_state_t state;
	iopr_pkg::iopr_apb_state_t next_state;

	wire [NUM_PINS-1:0] impl = PIN_MASK[NUM_PINS-1:0];

	// Byte-lane merge of a write into an existing word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b])
				res[b*8 +: 8] = wd[b*8 +: 8];
		end
		return res;
	endfunction

	// APB: one wait-free access phase
	assign pready = 1'b1;
	always_comb begin
		case (state)
			iopr_pkg::IOPR_IDLE: next_state = (psel && !penable) ? iopr_pkg::IOPR_ACCESS
				: iopr_pkg::IOPR_IDLE;
			iopr_pkg::IOPR_ACCESS: next_state = (psel && !penable) ? iopr_pkg::IOPR_ACCESS
				: iopr_pkg::IOPR_IDLE;
			default: next_state = iopr_pkg::IOPR_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state <= iopr_pkg::IOPR_IDLE;
		else
			state <= next_state;
	end

	// Only an access phase that followed its own setup cycle counts
	wire access = psel && penable && (state == iopr_pkg::IOPR_ACCESS);
	wire wr = access && pwrite;
	wire hit_dir = (paddr == `IOPR_OFF_DIR);
	wire hit_latch = (paddr == `IOPR_OFF_LATCH);
	wire hit_level = (paddr == `IOPR_OFF_LEVEL);
	wire hit_analog = (paddr == `IOPR_OFF_ANALOG);
	wire hit_pen = (paddr == `IOPR_OFF_PERIPH_EN);
	wire [11:0] map_off = paddr - `IOPR_OFF_MAP_BASE;
	wire hit_map = (paddr >= `IOPR_OFF_MAP_BASE) && (paddr[1:0] == 2'b00)
		&& (32'(map_off[11:2]) < NUM_MAP);
	wire [9:0] map_idx = map_off[11:2];
	wire mapped = hit_dir || hit_latch || hit_level || hit_analog || hit_pen || hit_map;

	wire [31:0] dir_w = 32'(dir);
	wire [31:0] latch_w = 32'(latch);
	wire [31:0] analog_w = 32'(analog);
	wire [31:0] pen_w = 32'(periph_en);
	wire [31:0] level_w = 32'(level);

	// Selector pair of the addressed map register
	logic [31:0] map_word;
	always_comb begin
		map_word = 32'h0;
		for (int i = 0; i < NUM_MAP; i++) begin
			if (map_idx == 10'(i)) begin
				map_word[`IOPR_SEL_LO_POS +: 6] = map_sel[2*i];
				if (2*i + 1 < NUM_PINS)
					map_word[`IOPR_SEL_HI_POS +: 6] = map_sel[2*i + 1];
			end
		end
	end

	wire [31:0] next_dir_w = merge(dir_w, pwdata, pstrb);
	wire [31:0] next_latch_w = merge(latch_w, pwdata, pstrb);
	wire [31:0] next_analog_w = merge(analog_w, pwdata, pstrb);
	wire [31:0] next_pen_w = merge(pen_w, pwdata, pstrb);
	wire [31:0] next_map_w = merge(map_word, pwdata, pstrb);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir <= NUM_PINS'(`IOPR_DIR_RESET);
			analog <= NUM_PINS'(`IOPR_ANALOG_RESET);
			periph_en <= '0;
		end else if (wr) begin
			if (hit_dir)
				dir <= next_dir_w[NUM_PINS-1:0] | ~impl;
			if (hit_analog)
				analog <= next_analog_w[NUM_PINS-1:0] & impl;
			if (hit_pen)
				periph_en <= next_pen_w[NUM_PINS-1:0] & impl;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			latch <= NUM_PINS'(`IOPR_LATCH_RESET);
		else if (wr && (hit_latch || hit_level))
			latch <= next_latch_w[NUM_PINS-1:0] & impl;
	end

	generate
		for (genvar p = 0; p < NUM_PINS; p++) begin : g_map
			localparam int M = p / 2;
			localparam int POS = (p % 2 == 0) ? `IOPR_SEL_LO_POS : `IOPR_SEL_HI_POS;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					map_sel[p] <= `IOPR_MAP_RESET;
				else if (wr && hit_map && map_idx == 10'(M) && REMAP_MASK[p] && impl[p])
					map_sel[p] <= next_map_w[POS +: 6];
			end
		end
	endgenerate

	// Pin level: pads are asynchronous, two flops first
	logic [NUM_PINS-1:0] pad_sync;
	iopr_sync #(.WIDTH(NUM_PINS)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(pad_in),
		.sync_out(pad_sync)
	);
	assign level = pad_sync & impl & ~analog;

	// Per-pin ownership
	logic [NUM_PINS-1:0] rp_data;
	logic [NUM_PINS-1:0] rp_drive;
	logic [NUM_PINS-1:0] next_pad_out;
	logic [NUM_PINS-1:0] next_pad_oe;
	generate
		for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
			if (REMAP_MASK[p]) begin : g_rp
				iopr_outmap #(.NUM_SRC(NUM_SRC)) u_map (
					.sel(map_sel[p]),
					.src_data(src_data),
					.src_drive(src_drive),
					.map_data(rp_data[p]),
					.map_drive(rp_drive[p])
				);
			end else begin : g_fixed
				// Fixed-only sharing: fixed peripheral when enabled and driving, else the port pin
				assign rp_data[p] = 1'b0;
				assign rp_drive[p] = 1'b0;
			end
			wire remap_own = rp_drive[p];
			wire fixed_own = periph_en[p] && fixed_drive[p];
			wire port_oe = !dir[p];
			assign next_pad_out[p] = remap_own ? rp_data[p] : fixed_own ? fixed_data[p]
				: latch[p];
			assign next_pad_oe[p] = impl[p] && !analog[p] && (remap_own || fixed_own || port_oe);
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_out <= '0;
			pad_oe <= '0;
		end else begin
			pad_out <= next_pad_out;
			pad_oe <= next_pad_oe;
		end
	end

	// Peripherals see only the sampled pad, never the latch, so no loop-through
	assign periph_in = level;
	assign analog_sel = analog;

	wire [31:0] rd_dir = dir_w & PIN_MASK;
	wire [31:0] rd_latch = latch_w & PIN_MASK;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			if (hit_dir)
				prdata <= rd_dir;
			else if (hit_latch)
				prdata <= rd_latch;
			else if (hit_level)
				prdata <= level_w;
			else if (hit_analog)
				prdata <= analog_w;
			else if (hit_pen)
				prdata <= pen_w;
			else if (hit_map)
				prdata <= map_word;
			else
				prdata <= 32'h0;
		end
	end

	assign pslverr = access && !mapped;
endmodule

/* File: sim/iopr_port_sva.sv */
`timescale 1ns/1ps
module iopr_port_sva #(
	parameter int NUM_PINS = 16
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins
	input wire logic [NUM_PINS-1:0] pad_in,
	input wire logic [NUM_PINS-1:0] pad_oe,
	input wire logic [NUM_PINS-1:0] periph_in,
	input wire logic [NUM_PINS-1:0] analog_sel
);
	logic [1:0] up;
	wire acc = psel && penable;
	wire rd = acc && !pwrite;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Sync history is only valid once both flops refilled after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			up <= 2'd0;
		else if (up != 2'd3)
			up <= up + 2'd1;
	end
	chk_ready_high: assert property (psel |-> pready)
		else $error("pready low in transfer");
	chk_err_phase: assert property (pslverr |-> acc)
		else $error("pslverr outside access");
	chk_err_unmapped: assert property (acc && paddr == 12'h014 |-> pslverr)
		else $error("unmapped access not refused");
	chk_ok_mapped: assert property (acc && paddr[11:4] == 8'h00 && paddr[1:0] == 2'b00 |-> !pslverr)
		else $error("mapped access refused");
	chk_err_rdzero: assert property (rd && pslverr |-> prdata == 32'h0)
		else $error("refused read not zero");
	chk_upper_zero: assert property (rd && paddr < 12'h00c |-> (prdata >> NUM_PINS) == 32'h0)
		else $error("absent bits read nonzero");
	chk_reset_inputs: assert property (up != 2'd3 |-> pad_oe == '0)
		else $error("pin driven right after reset");
	chk_in_sync: assert property (up == 2'd3 && $stable(analog_sel)
		&& analog_sel == $past(analog_sel, 2)
		|-> (periph_in & ~analog_sel) == ($past(pad_in, 2) & ~analog_sel))
		else $error("peripheral input not pin level");
	cover property (rd && paddr == 12'h008);
	cover property (acc && pslverr);
	cover property (pad_oe != '0);
endmodule

bind iopr_port iopr_port_sva #(.NUM_PINS(NUM_PINS)) u_sva (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .prdata, .pready, .pslverr, .pad_in, .pad_oe, .periph_in, .analog_sel);

/* File: sim/iopr_pins.sv */
`timescale 1ns/1ps
module iopr_pins #(
	parameter int NUM_PINS = 16
) (
	// Pads
	input wire logic [NUM_PINS-1:0] pad_out,
	input wire logic [NUM_PINS-1:0] pad_oe,
	output logic [NUM_PINS-1:0] pad_in,
	// Board drive
	input wire logic [NUM_PINS-1:0] ext_val,
	input wire logic [NUM_PINS-1:0] ext_en
);
	// Undriven pins float high through board pull-ups
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ((ext_en & ext_val) | ~ext_en));
endmodule

/* File: sim/io_port_with_output_remap_tb.sv */
`timescale 1ns/1ps
module io_port_with_output_remap_tb;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdata, v;
	logic [3:0] pstrb;
	logic [15:0] fixed_data, fixed_drive, periph_in, analog_sel, pad_in, pad_out, pad_oe;
	logic [15:0] ext_val, ext_en, lat;
	logic [27:0] src_data, src_drive;
	int seed = 32'h1543;
	int bad_count = 0;
	int comparisons = 0;
	always #20 pclk = ~pclk;
	iopr_port uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
		.pready, .pslverr, .fixed_data, .fixed_drive, .src_data, .src_drive, .periph_in,
		.analog_sel, .pad_in, .pad_out, .pad_oe);
	iopr_pins brd (.pad_out, .pad_oe, .pad_in, .ext_val, .ext_en);
	function automatic logic [15:0] drv(input logic [31:0] r, input logic [15:0] l);
		return (r[15:0] & r[31:16]) | (~r[15:0] & l);
	endfunction
	function automatic logic sel_on(input int c);
		return c >= 1 && c <= 27;
	endfunction
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			bad_count++;
			conclude();
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rdata, exp);
	endtask
	task automatic settle();
		repeat (4) @(posedge pclk);
		@(negedge pclk);
	endtask
	initial begin
		{presetn, psel, penable, pwrite} = 4'h0;
		{paddr, pwdata, pstrb} = 48'h00f;
		{fixed_data, fixed_drive, ext_val, ext_en} = 64'h0;
		{src_data, src_drive} = 56'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h000, 32'h0000ffff);
		rd(12'h004, 32'h0);
		rd(12'h020, 32'h0);
		rd(12'h00c, 32'h0);
		@(negedge pclk);
		check(pad_oe, 16'h0);
		$display("reset values done");
		repeat (4) begin
			v = $random(seed);
			apb(1'b1, 12'h004, v);
			rd(12'h004, {16'h0, v[15:0]});
			v = $random(seed);
			lat = v[15:0];
			apb(1'b1, 12'h008, v);
			rd(12'h004, {16'h0, lat});
			v = $random(seed);
			ext_val <= v[15:0];
			ext_en <= v[31:16];
			settle();
			rd(12'h008, {16'h0, (v[15:0] & v[31:16]) | ~v[31:16]});
		end
		pstrb <= 4'h2;
		apb(1'b1, 12'h004, 32'h0000a5c3);
		pstrb <= 4'hf;
		rd(12'h004, {16'h0, 8'ha5, lat[7:0]});
		lat = {8'ha5, lat[7:0]};
		$display("register access done");
		apb(1'b1, 12'h010, 32'h0000ffff);
		apb(1'b1, 12'h000, 32'h0);
		repeat (4) begin
			v = $random(seed);
			@(posedge pclk);
			fixed_drive <= v[15:0];
			fixed_data <= v[31:16];
			settle();
			check(pad_oe, 16'hffff);
			check(pad_out, drv(v, lat));
			rd(12'h008, {16'h0, drv(v, lat)});
		end
		apb(1'b1, 12'h000, 32'h0000ffff);
		settle();
		check(pad_oe, v[15:0]);
		$display("pin ownership done");
		v = $random(seed);
		@(posedge pclk);
		src_drive <= 28'hfffffff;
		src_data <= v[27:0];
		apb(1'b1, 12'h010, 32'h0);
		for (int c = 0; c < 32; c++) begin
			apb(1'b1, 12'h020, {18'h0, 6'(63 - c), 2'b00, 6'(c)});
			settle();
			check(pad_oe, {14'h0, sel_on(63 - c), sel_on(c)});
			if (sel_on(c))
				check(pad_out[0], v[c]);
		end
		rd(12'h020, 32'h0000201f);
		apb(1'b1, 12'h014, 32'hffffffff);
		check(rerr, 1'b1);
		rd(12'h014, 32'h0);
		apb(1'b1, 12'h00c, 32'h000000f0);
		settle();
		check(analog_sel, 16'h00f0);
		rd(12'h008, {16'h0, ((ext_val & ext_en) | ~ext_en) & 16'hff0f});
		$display("remap and decode done");
		conclude();
	end
endmodule
